// >>> logic/flash_fe_pkg.sv
// Purpose: shared constants and types for the serial flash front end
// Assumes: ref_clk at 40 MHz, serial clock sampled as a plain input
// Notes:   every number used by more than one file lives here
package flash_fe_pkg;

  // ----------------------------------------------------------------
  // clocking and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  // self-timed program/erase duration, a plain default
  localparam int PROG_TIME_NS = 1000000;
  localparam int PROG_CYCLES = (PROG_TIME_NS * 1000) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // serial framing
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int BIT_CNT_W = 3;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  // pin order {select_n, sclk, sdi}; idle has select high
  localparam logic [2:0] PIN_IDLE = 3'h4;
  localparam int PIN_SEL = 2;
  localparam int PIN_CLK = 1;
  localparam int PIN_DAT = 0;

  // ----------------------------------------------------------------
  // memory organisation
  // ----------------------------------------------------------------
  localparam int PAGE_BYTES_STD = 256;
  localparam int PAGE_BYTES_ALT = 264;
  localparam int PAGE_COUNT = 1024;
  localparam int BUF_ADDR_W = 9;
  localparam int PAGE_ADDR_W = 10;

  // ----------------------------------------------------------------
  // link states
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ST_STANDBY = 2'b00,
    ST_SELECTED = 2'b01,
    ST_FINISHING = 2'b10
  } link_state_t;

endpackage

// >>> logic/byte_stream_if.sv
// Purpose: byte stream with valid/ready between internal modules
// Assumes: both ends on ref_clk
// Notes:   data and valid held until ready is seen
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if;
  logic [7:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// >>> logic/byte_skid_buffer.sv
// Purpose: two-entry buffer in the received data path
// Assumes: synchronous active-high reset on ref_clk
// Notes:   outputs and ready all come from flip-flops
`timescale 1ns/1ps
`default_nettype none
module byte_skid_buffer
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // filling side
  byte_stream_if.snk in_s,
  // draining side
  byte_stream_if.src out_s
);

  logic [7:0] out_data;
  logic out_valid;
  logic [7:0] spare_data;
  logic spare_valid;
  logic in_fire;
  logic out_free;

  // ----------------------------------------------------------------
  // handshake decode
  // ----------------------------------------------------------------
  // ready drops only when both entries hold data
  assign in_s.ready = ~spare_valid;
  assign in_fire = in_s.valid & ~spare_valid;
  assign out_free = ~out_valid | out_s.ready;
  assign out_s.data = out_data;
  assign out_s.valid = out_valid;

  // output stage takes the spare first so order is kept
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data <= 8'h00;
    end
    else if (out_free)
    begin
      out_valid <= spare_valid | in_fire;
      out_data <= spare_valid ? spare_data : in_s.data;
    end
  end

  // spare entry catches a byte while the drain stalls
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      spare_valid <= 1'b0;
      spare_data <= 8'h00;
    end
    else if (out_free)
      spare_valid <= 1'b0;
    else if (in_fire)
    begin
      spare_valid <= 1'b1;
      spare_data <= in_s.data;
    end
  end

endmodule
`default_nettype wire

// >>> logic/serial_flash_spi_front_end.sv
// Purpose: serial interface front end of a page-organised serial flash
// Assumes: ref_clk far faster than the serial clock; pins asynchronous
// Notes:   serial clock is oversampled, never used as a clock
`timescale 1ns/1ps
`default_nettype none
// Function
// - raising select deselects the part, floats the output and enters standby unless a timed operation is running.
// - input bits are ignored while the part is not selected.
// - operations start on a select fall and end on a select rise.
// - a select rise during a timed operation delays standby until it ends.
// - input bits are sampled on each rising serial clock edge.
// - output bits change on each falling serial clock edge.
// - the serial clock may idle low or high (modes 0 and 3).
// - a page holds 256 bytes, or 264 when the alternate size is chosen.
// - the main array has 1024 pages of the configured size.
// - one data buffer exists whose size follows the page size.
// - program and erase are timed internally, needing no serial clock.
// - all bytes move most significant bit first both ways.
module serial_flash_spi_front_end
#(
  parameter int PROG_CYCLES = flash_fe_pkg::PROG_CYCLES
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // link status
  output logic standby,
  output logic overrun,
  // received bytes
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // bytes to send
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // self-timed operation
  input wire logic op_start,
  input wire logic [flash_fe_pkg::PAGE_ADDR_W-1:0] op_page,
  output logic busy,
  output logic op_done,
  output logic [flash_fe_pkg::PAGE_ADDR_W-1:0] active_page,
  // data buffer access
  input wire logic page_264,
  input wire logic buf_we,
  input wire logic [flash_fe_pkg::BUF_ADDR_W-1:0] buf_addr,
  input wire logic [7:0] buf_wdata,
  output logic [7:0] buf_rdata
);

  localparam int TIMER_W = $clog2(PROG_CYCLES + 1);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_in;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] pin_f;
  logic [2:0] pin_q;

  assign pin_in = {cs_n, sck, si};

  // three stages; a level counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sync
      always_ff @(posedge ref_clk)
      begin
        if (rst)
        begin
          sync1[g] <= flash_fe_pkg::PIN_IDLE[g];
          sync2[g] <= flash_fe_pkg::PIN_IDLE[g];
          sync3[g] <= flash_fe_pkg::PIN_IDLE[g];
          pin_f[g] <= flash_fe_pkg::PIN_IDLE[g];
          pin_q[g] <= flash_fe_pkg::PIN_IDLE[g];
        end
        else
        begin
          sync1[g] <= pin_in[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          if (sync2[g] == sync3[g])
            pin_f[g] <= sync3[g];
          pin_q[g] <= pin_f[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // edge decode
  // ----------------------------------------------------------------
  // edges found on the filtered copy, so the clock may idle either way
  wire cs_fall = pin_q[flash_fe_pkg::PIN_SEL] & ~pin_f[flash_fe_pkg::PIN_SEL];
  wire cs_rise = ~pin_q[flash_fe_pkg::PIN_SEL] & pin_f[flash_fe_pkg::PIN_SEL];
  wire sck_rise = ~pin_q[flash_fe_pkg::PIN_CLK] & pin_f[flash_fe_pkg::PIN_CLK];
  wire sck_fall = pin_q[flash_fe_pkg::PIN_CLK] & ~pin_f[flash_fe_pkg::PIN_CLK];
  wire si_bit = pin_f[flash_fe_pkg::PIN_DAT];

  // ----------------------------------------------------------------
  // link state machine
  // ----------------------------------------------------------------
  flash_fe_pkg::link_state_t state;
  flash_fe_pkg::link_state_t next_state;
  logic selected;

  // a select fall during finishing re-selects, e.g. for status polling
  always_comb
  begin
    next_state = state;
    case (state)
      flash_fe_pkg::ST_STANDBY:
        if (cs_fall)
          next_state = flash_fe_pkg::ST_SELECTED;
      flash_fe_pkg::ST_SELECTED:
        if (cs_rise)
          next_state = busy ? flash_fe_pkg::ST_FINISHING
                            : flash_fe_pkg::ST_STANDBY;
      flash_fe_pkg::ST_FINISHING:
        if (cs_fall)
          next_state = flash_fe_pkg::ST_SELECTED;
        else if (!busy)
          next_state = flash_fe_pkg::ST_STANDBY;
      default:
        next_state = flash_fe_pkg::ST_STANDBY;
    endcase
  end

  assign selected = (state == flash_fe_pkg::ST_SELECTED);

  // standby and output enable follow the next state, both registered
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= flash_fe_pkg::ST_STANDBY;
      standby <= 1'b1;
      so_oe <= 1'b0;
    end
    else
    begin
      state <= next_state;
      standby <= (next_state == flash_fe_pkg::ST_STANDBY);
      so_oe <= (next_state == flash_fe_pkg::ST_SELECTED);
    end
  end

  // ----------------------------------------------------------------
  // receive shifter
  // ----------------------------------------------------------------
  logic [flash_fe_pkg::BIT_CNT_W-1:0] bit_cnt;
  logic [6:0] in_shift;
  logic first_done;
  byte_stream_if rx_in ();
  byte_stream_if rx_out ();

  // sampling gated by selection so deselected traffic is dropped
  wire take_bit = selected & sck_rise;
  wire byte_end = take_bit & (bit_cnt == flash_fe_pkg::LAST_BIT);
  wire [7:0] rx_byte = {in_shift, si_bit};

  always_ff @(posedge ref_clk)
  begin
    if (rst || cs_fall)
    begin
      bit_cnt <= '0;
      in_shift <= 7'h00;
    end
    else if (take_bit)
    begin
      bit_cnt <= bit_cnt + 3'h1;
      in_shift <= rx_byte[6:0];
    end
  end

  // first completed byte is the opcode; later bytes may be answered
  always_ff @(posedge ref_clk)
  begin
    if (rst || cs_fall)
      first_done <= 1'b0;
    else if (byte_end)
      first_done <= 1'b1;
  end

  // a full buffer drops the byte and flags it until the next select
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rx_in.valid <= 1'b0;
      rx_in.data <= 8'h00;
      overrun <= 1'b0;
    end
    else
    begin
      rx_in.valid <= byte_end & rx_in.ready;
      if (byte_end)
        rx_in.data <= rx_byte;
      if (byte_end && !rx_in.ready)
        overrun <= 1'b1;
      else if (cs_fall)
        overrun <= 1'b0;
    end
  end

  byte_skid_buffer rx_buf
  (
    .ref_clk (ref_clk),
    .rst (rst),
    .in_s (rx_in),
    .out_s (rx_out)
  );

  assign rx_out.ready = rx_ready;
  assign rx_data = rx_out.data;
  assign rx_valid = rx_out.valid;

  // ----------------------------------------------------------------
  // transmit shifter
  // ----------------------------------------------------------------
  logic [7:0] tx_hold;
  logic tx_full;
  logic [6:0] out_shift;

  // a new byte is loaded at the falling edge that starts it
  wire drive_bit = selected & sck_fall;
  wire load_byte = drive_bit & (bit_cnt == '0);
  wire take_tx = load_byte & first_done & tx_full;
  wire accept_tx = tx_valid & tx_ready;
  wire next_full = (tx_full & ~take_tx) | accept_tx;
  wire [7:0] load_val = take_tx ? tx_hold : flash_fe_pkg::FILL_BYTE;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      tx_full <= 1'b0;
      tx_ready <= 1'b1;
      tx_hold <= 8'h00;
    end
    else
    begin
      tx_full <= next_full;
      tx_ready <= ~next_full;
      if (accept_tx)
        tx_hold <= tx_data;
    end
  end

  // msb first; a select fall refills so mode 0 opcodes read as fill
  always_ff @(posedge ref_clk)
  begin
    if (rst || cs_fall)
    begin
      so <= 1'b1;
      out_shift <= flash_fe_pkg::FILL_BYTE[6:0];
    end
    else if (load_byte)
    begin
      so <= load_val[7];
      out_shift <= load_val[6:0];
    end
    else if (drive_bit)
    begin
      so <= out_shift[6];
      out_shift <= {out_shift[5:0], flash_fe_pkg::FILL_BYTE[0]};
    end
  end

  // ----------------------------------------------------------------
  // self-timed program and erase
  // ----------------------------------------------------------------
  logic [TIMER_W-1:0] op_timer;

  // counts on ref_clk alone; the host may stop the serial clock
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      op_done <= 1'b0;
      op_timer <= '0;
      active_page <= '0;
    end
    else
    begin
      op_done <= 1'b0;
      if (op_start && !busy)
      begin
        busy <= 1'b1;
        op_timer <= TIMER_W'(PROG_CYCLES - 1);
        active_page <= op_page;
      end
      else if (busy && op_timer == '0)
      begin
        busy <= 1'b0;
        op_done <= 1'b1;
      end
      else if (busy)
        op_timer <= op_timer - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // page data buffer
  // ----------------------------------------------------------------
  logic [7:0] page_mem [0:flash_fe_pkg::PAGE_BYTES_ALT-1];
  logic [flash_fe_pkg::BUF_ADDR_W-1:0] page_limit;
  logic [flash_fe_pkg::BUF_ADDR_W-1:0] buf_idx;

  // addresses past the page end wrap, so the buffer tracks page size
  assign page_limit = page_264
    ? flash_fe_pkg::BUF_ADDR_W'(flash_fe_pkg::PAGE_BYTES_ALT)
    : flash_fe_pkg::BUF_ADDR_W'(flash_fe_pkg::PAGE_BYTES_STD);
  assign buf_idx = (buf_addr >= page_limit) ? buf_addr - page_limit
                                            : buf_addr;

  // single port; read returns the old byte on a write cycle
  always_ff @(posedge ref_clk)
  begin
    if (buf_we)
      page_mem[buf_idx] <= buf_wdata;
    buf_rdata <= page_mem[buf_idx];
  end

endmodule
`default_nettype wire

// >>> testbench/spi_host_model.sv
// Purpose: behavioural host driving the serial pins of the front end
// Assumes: called from the bench right after a ref_clk rising edge
// Notes:   link clock period is 8 ref_clk cycles, 200 ns
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
(
  // clock
  input wire logic ref_clk,
  // serial pins
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so
);
  // ------------------------------------------------
  // pin drivers
  // ------------------------------------------------
  logic bit_out = 1'b0;
  logic noise = 1'b0;
  initial cs_n = 1'b1;
  initial sck = 1'b0;
  // a released data line must not keep its last bit: toggle it
  always @(posedge ref_clk)
    noise <= ~noise;
  assign si = cs_n ? noise : bit_out;
  // park the clock at its idle level, then move select
  task automatic edge_cs(input logic go, input logic m3);
    @(posedge ref_clk);
    sck <= m3;
    repeat (4) @(posedge ref_clk);
    cs_n <= ~go;
    repeat (8) @(posedge ref_clk);
  endtask
  // data changes while the clock is low; so is read late in the
  // high phase because the part answers a few cycles after the fall
  task automatic xfer(input logic [7:0] d, input int nb,
    output logic [7:0] q);
    q = 8'hff;
    @(posedge ref_clk);
    for (int i = 7; i > 7 - nb; i--)
    begin
      sck <= 1'b0;
      bit_out <= d[i];
      repeat (4) @(posedge ref_clk);
      sck <= 1'b1;
      repeat (4) @(posedge ref_clk);
      q[i] = so;
    end
  endtask
endmodule
`default_nettype wire

// >>> testbench/serial_flash_spi_front_end_asserts.sv
// Purpose: port-level checks on the serial flash front end
// Assumes: one clock domain, rst synchronous active high
// Notes:   busy length is counted in helper logic
`timescale 1ns/1ps
`default_nettype none
module serial_flash_spi_front_end_asserts
#(
  parameter int PROG_CYCLES = flash_fe_pkg::PROG_CYCLES
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic so,
  input wire logic so_oe,
  // status and streams
  input wire logic standby,
  input wire logic overrun,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic busy,
  input wire logic op_done
);
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  int busy_cnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // run length of busy, compared with the parameter when it falls
  always_ff @(posedge ref_clk)
    busy_cnt <= (rst || !busy) ? 0 : busy_cnt + 1;
  property p_float; cs_n[*8] |=> !so_oe; endproperty
  a_float: assert property (p_float)
    else $error("output driven while deselected");
  property p_idle; cs_n[*8] ##0 (!busy && !$past(busy)) |=> standby;
  endproperty
  a_idle: assert property (p_idle)
    else $error("no standby after deselect");
  property p_hold; busy && cs_n |-> !standby; endproperty
  a_hold: assert property (p_hold)
    else $error("standby while timed op runs");
  property p_wake; $fell(standby) |-> !cs_n; endproperty
  a_wake: assert property (p_wake)
    else $error("left standby without select");
  property p_len; $fell(busy) |-> busy_cnt == PROG_CYCLES && op_done;
  endproperty
  a_len: assert property (p_len)
    else $error("timed op length wrong");
  property p_so;
    $changed(so) && !cs_n && !$past(cs_n, 8)
      |-> !$past(sck, 4) || !$past(sck, 5);
  endproperty
  a_so: assert property (p_so)
    else $error("output changed away from a clock fall");
  property p_rxh; rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
  endproperty
  a_rxh: assert property (p_rxh)
    else $error("stalled byte not held");
  property p_ovr; $fell(cs_n) |-> ##[2:8] !overrun; endproperty
  a_ovr: assert property (p_ovr)
    else $error("overrun not cleared at select");
  c_op: cover property ($fell(busy));
  c_ovr: cover property ($rose(overrun));
  c_rx: cover property (rx_valid && rx_ready);
endmodule
bind serial_flash_spi_front_end serial_flash_spi_front_end_asserts
  #(.PROG_CYCLES(PROG_CYCLES)) chk (.ref_clk, .rst, .cs_n, .sck, .so,
  .so_oe, .standby, .overrun, .rx_data, .rx_valid, .rx_ready, .busy,
  .op_done);
`default_nettype wire

// >>> testbench/serial_flash_spi_front_end_bench.sv
// Purpose: self-checking bench for the serial flash front end
// Assumes: 40 MHz ref_clk, 200 ns link clock from the host model
// Notes:   timed operation shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module serial_flash_spi_front_end_bench;
  // ------------------------------------------------
  // signals and instances
  // ------------------------------------------------
  localparam int PROG = 20;
  logic ref_clk = 1'b0, rst = 1'b1, rx_ready = 1'b1, tx_valid = 1'b0;
  logic op_start = 1'b0, page_264 = 1'b0, buf_we = 1'b0;
  logic [7:0] tx_data = 8'h00, buf_wdata = 8'h00;
  logic [9:0] op_page = 10'h000;
  logic [8:0] buf_addr = 9'h000;
  logic cs_n, sck, si, so, so_oe, standby, overrun, rx_valid, tx_ready;
  logic busy, op_done;
  logic [7:0] rx_data, buf_rdata, q;
  logic [9:0] active_page;
  logic [7:0] rxq[$];
  int errors = 0, total_checks = 0, cycles = 0;
  serial_flash_spi_front_end #(.PROG_CYCLES(PROG)) DUT (.ref_clk, .rst,
    .cs_n, .sck, .si, .so, .so_oe, .standby, .overrun, .rx_data,
    .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready, .op_start,
    .op_page, .busy, .op_done, .active_page, .page_264, .buf_we,
    .buf_addr, .buf_wdata, .buf_rdata);
  spi_host_model host (.ref_clk, .cs_n, .sck, .si, .so);
  always #12.5 ref_clk = ~ref_clk;
  // bytes the consumer takes are queued for later comparison
  always @(posedge ref_clk)
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      rxq.push_back(rx_data);
  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 6000)
      stop_test(1);
  end
  task automatic chk(input string what, input logic [9:0] exp,
    input logic [9:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test(input int hung);
    errors += hung;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic acc(input logic we, input logic [8:0] a);
    @(posedge ref_clk);
    buf_we <= we;
    buf_addr <= a;
    buf_wdata <= a[8:1] ^ 8'h5a;
    @(posedge ref_clk);
    buf_we <= 1'b0;
    @(posedge ref_clk);
  endtask
  // mode 3 gets no send byte, so the fill path is checked; its early fall loads fill
  task automatic t_frame(input logic m3, input logic use_tx);
    rxq.delete();
    tx_data <= 8'h96;
    tx_valid <= use_tx;
    do @(posedge ref_clk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
    host.edge_cs(1'b1, m3);
    chk("standby", 0, standby);
    chk("so_oe", 1, so_oe);
    host.xfer(8'ha5, 8, q);
    chk("opcode out", 8'hff, q);
    host.xfer(8'h3c, 8, q);
    chk("data out", use_tx ? 8'h96 : 8'hff, q);
    host.edge_cs(1'b0, m3);
    chk("so_oe", 0, so_oe);
    chk("standby", 1, standby);
    chk("rx count", 2, rxq.size());
    chk("opcode in", 8'ha5, rxq[0]);
    chk("data in", 8'h3c, rxq[1]);
    $display("test frame mode %0d done", m3 ? 3 : 0);
  endtask
  task automatic t_ignore();
    rxq.delete();
    host.xfer(8'h00, 8, q);
    host.edge_cs(1'b1, 1'b0);
    host.xfer(8'h5a, 3, q);
    host.edge_cs(1'b0, 1'b0);
    host.edge_cs(1'b1, 1'b0);
    host.xfer(8'hc3, 8, q);
    host.edge_cs(1'b0, 1'b0);
    chk("rx count", 1, rxq.size());
    chk("rx byte", 8'hc3, rxq[0]);
    $display("test ignore done");
  endtask
  task automatic t_busy();
    int n;
    host.edge_cs(1'b1, 1'b0);
    op_page <= 10'h2a5;
    op_start <= 1'b1;
    @(posedge ref_clk);
    op_start <= 1'b0;
    host.edge_cs(1'b0, 1'b0);
    chk("busy", 1, busy);
    chk("standby", 0, standby);
    chk("page", 10'h2a5, active_page);
    for (n = 0; n < 40 && op_done !== 1'b1; n++)
      @(posedge ref_clk);
    chk("op_done", 1, op_done);
    repeat (2) @(posedge ref_clk);
    chk("standby", 1, standby);
    $display("test busy done");
  endtask
  task automatic t_buf();
    acc(1'b1, 9'h000);
    page_264 <= 1'b1;
    acc(1'b1, 9'h100);
    acc(1'b0, 9'h100);
    chk("buf 264", 8'h5a ^ 8'h80, buf_rdata);
    page_264 <= 1'b0;
    acc(1'b0, 9'h100);
    chk("buf wrap", 8'h5a, buf_rdata);
    $display("test buffer done");
  endtask
  task automatic t_full();
    rxq.delete();
    rx_ready <= 1'b0;
    host.edge_cs(1'b1, 1'b0);
    // opcode, then three address bytes; the last two overflow
    host.xfer(8'h81, 8, q);
    host.xfer(8'h42, 8, q);
    host.xfer(8'h24, 8, q);
    host.xfer(8'h18, 8, q);
    host.edge_cs(1'b0, 1'b0);
    chk("overrun", 1, overrun);
    chk("held", 8'h81, rx_data);
    rx_ready <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("drained", 2, rxq.size());
    chk("second", 8'h42, rxq[1]);
    chk("rx_valid", 0, rx_valid);
    host.edge_cs(1'b1, 1'b0);
    chk("overrun", 0, overrun);
    host.edge_cs(1'b0, 1'b0);
    $display("test full done");
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    t_frame(1'b0, 1'b1);
    t_frame(1'b1, 1'b0);
    t_ignore();
    t_busy();
    t_buf();
    t_full();
    stop_test(0);
  end
endmodule
`default_nettype wire
